// >>> verilog/mcuic_regs.svh
`ifndef MCUIC_REGS_SVH
`define MCUIC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets on the register port (one address bit).
// ----------------------------------------------------------------------
`define MCUIC_OFS_PRIMARY   1'h0
`define MCUIC_OFS_SECONDARY 1'h1

// ----------------------------------------------------------------------
// Field positions in irq_control_primary.
// ----------------------------------------------------------------------
`define MCUIC_PRI_GLB_EN    0
`define MCUIC_PRI_EXT_EN    1
`define MCUIC_PRI_T0_EN     2
`define MCUIC_PRI_T1_EN     3
`define MCUIC_PRI_EXT_FLAG  4
`define MCUIC_PRI_T0_FLAG   5
`define MCUIC_PRI_T1_FLAG   6

// ----------------------------------------------------------------------
// Field positions in irq_control_secondary.
// ----------------------------------------------------------------------
`define MCUIC_SEC_ADC_EN    0
`define MCUIC_SEC_ADC_FLAG  4

// ----------------------------------------------------------------------
// Reset values and vectors.
// ----------------------------------------------------------------------
`define MCUIC_RST_PRIMARY   8'h00
`define MCUIC_RST_SECONDARY 8'h00
`define MCUIC_VEC_EXT       8'h04
`define MCUIC_VEC_T0        8'h08
`define MCUIC_VEC_T1        8'h0C
`define MCUIC_VEC_ADC       8'h10

// ----------------------------------------------------------------------
// Timing: system clocks per machine cycle, and stack depth.
// ----------------------------------------------------------------------
`define MCUIC_PHASE_DIV     4
`define MCUIC_STACK_DEPTH   6

`endif

// >>> verilog/mcuic_pkg.sv
`default_nettype none

package mcuic_pkg;

  // Source index; the enum order is also the service priority.
  typedef enum logic [1:0] {
    MCUIC_SRC_EXT,
    MCUIC_SRC_T0,
    MCUIC_SRC_T1,
    MCUIC_SRC_ADC
  } mcuic_src_t;

  typedef logic [3:0] mcuic_src_vec_t;

  typedef enum logic {
    MCUIC_RUN,
    MCUIC_SLEEP
  } mcuic_core_state_t;

  // Highest-priority pending source; callers gate with |req.
  function automatic mcuic_src_t mcuic_pick(input mcuic_src_vec_t req);
    mcuic_src_t s;
    s = MCUIC_SRC_ADC;
    if (req[2]) begin
      s = MCUIC_SRC_T1;
    end
    if (req[1]) begin
      s = MCUIC_SRC_T0;
    end
    if (req[0]) begin
      s = MCUIC_SRC_EXT;
    end
    return s;
  endfunction

endpackage

`default_nettype wire

// >>> verilog/mcuic_if.sv
`timescale 1ns/10ps
`default_nettype none

interface mcuic_if #(
  parameter int PC_W = 12
);
  logic            reg_addr;
  logic [7:0]      reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [7:0]      reg_rdata;
  logic            phase_two;
  logic            stack_full;
  logic            power_down;
  logic            irq_take;
  logic [PC_W-1:0] irq_vector;
  logic            wake;

  modport dev (
    input  reg_addr,
    input  reg_wdata,
    input  reg_wr,
    input  reg_rd,
    output reg_rdata,
    input  phase_two,
    input  stack_full,
    input  power_down,
    output irq_take,
    output irq_vector,
    output wake
  );

  modport core (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input  reg_rdata,
    output phase_two,
    output stack_full,
    output power_down,
    input  irq_take,
    input  irq_vector,
    input  wake
  );
endinterface

`default_nettype wire

// >>> verilog/mcuic_dev.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "mcuic_regs.svh"

module mcuic_dev
  import mcuic_pkg::*;
#(
  parameter int PC_W = 12
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  mcuic_if.dev      bus,
  input  wire logic port_a_line5,
  input  wire logic port_a_dir_bit5,
  input  wire logic pull_high_option,
  input  wire logic timer0_ovf,
  input  wire logic timer1_ovf,
  input  wire logic adc_done,
  output var  logic pull_high_en,
  output var  logic ext_pin_is_irq
);

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  logic            glb_en_ff;
  mcuic_src_vec_t  en_ff;
  mcuic_src_vec_t  flag_ff;
  logic            pin_prev_ff;
  logic            take_ff;
  logic [PC_W-1:0] vector_ff;
  logic            wake_ff;
  logic [7:0]      rdata_ff;
  logic            pull_ff;
  logic            pin_irq_ff;

  logic            wr_pri;
  logic            wr_sec;
  logic            ext_fall;
  mcuic_src_vec_t  evt;
  mcuic_src_vec_t  pend;
  logic            accept;
  mcuic_src_t      pick;
  mcuic_src_vec_t  clr_mask;
  logic [7:0]      nxt_vec8;
  logic [7:0]      pri_view;
  logic [7:0]      sec_view;

  localparam logic [7:0] RST_PRI = `MCUIC_RST_PRIMARY;

  // --------------------------------------------------------------------
  // Register decode.
  // --------------------------------------------------------------------
  assign wr_pri = bus.reg_wr && (bus.reg_addr == `MCUIC_OFS_PRIMARY);
  assign wr_sec = bus.reg_wr && (bus.reg_addr == `MCUIC_OFS_SECONDARY);

  // --------------------------------------------------------------------
  // Event detection.
  // --------------------------------------------------------------------
  // The pin acts as the interrupt input only once software has enabled
  // it and made the line an input; otherwise port traffic is ignored.
  assign ext_fall = pin_prev_ff && !port_a_line5 && en_ff[0]
                    && port_a_dir_bit5;
  assign evt = {adc_done, timer1_ovf, timer0_ovf, ext_fall};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_prev_ff <= 1'b1;
    end else begin
      pin_prev_ff <= port_a_line5;
    end
  end

  // --------------------------------------------------------------------
  // Acceptance.
  // --------------------------------------------------------------------
  // Flags collect events at any time, but a decision is only made on
  // the machine phase pulse, so everything raised since the previous
  // pulse competes together.
  assign pend   = flag_ff & en_ff;
  assign accept = bus.phase_two && glb_en_ff
                  && !bus.stack_full && (|pend);
  assign pick   = mcuic_pick(pend);

  always_comb begin
    clr_mask = 4'h0;
    if (accept) begin
      clr_mask[pick] = 1'b1;
    end
  end

  always_comb begin
    unique case (pick)
      MCUIC_SRC_EXT: nxt_vec8 = `MCUIC_VEC_EXT;
      MCUIC_SRC_T0:  nxt_vec8 = `MCUIC_VEC_T0;
      MCUIC_SRC_T1:  nxt_vec8 = `MCUIC_VEC_T1;
      MCUIC_SRC_ADC: nxt_vec8 = `MCUIC_VEC_ADC;
    endcase
  end

  // The core pushes its next-instruction address on the same edge that
  // it sees irq_take and only then loads the vector.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      take_ff   <= 1'b0;
      vector_ff <= '0;
    end else begin
      take_ff <= accept;
      if (accept) begin
        vector_ff <= {{(PC_W-8){1'b0}}, nxt_vec8};
      end
    end
  end

  // --------------------------------------------------------------------
  // Global enable.
  // --------------------------------------------------------------------
  // Acceptance beats a software write in the same cycle, so a handler
  // can never be entered with nesting already open.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      glb_en_ff <= RST_PRI[`MCUIC_PRI_GLB_EN];
    end else if (accept) begin
      glb_en_ff <= 1'b0;
    end else if (wr_pri) begin
      glb_en_ff <= bus.reg_wdata[`MCUIC_PRI_GLB_EN];
    end
  end

  // --------------------------------------------------------------------
  // Per-source enables and request flags.
  // --------------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_src
    localparam int EN_POS = (i == 3) ? `MCUIC_SEC_ADC_EN
                                     : `MCUIC_PRI_EXT_EN + i;
    localparam int FL_POS = (i == 3) ? `MCUIC_SEC_ADC_FLAG
                                     : `MCUIC_PRI_EXT_FLAG + i;
    localparam logic [7:0] RST = (i == 3) ? `MCUIC_RST_SECONDARY
                                          : `MCUIC_RST_PRIMARY;
    logic sw_wr;
    assign sw_wr = (i == 3) ? wr_sec : wr_pri;

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        en_ff[i] <= RST[EN_POS];
      end else if (sw_wr) begin
        en_ff[i] <= bus.reg_wdata[EN_POS];
      end
    end

    // A new event wins over both the service clear and a software
    // clear in the same cycle, so no request is ever lost.
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        flag_ff[i] <= RST[FL_POS];
      end else if (evt[i]) begin
        flag_ff[i] <= 1'b1;
      end else if (clr_mask[i]) begin
        flag_ff[i] <= 1'b0;
      end else if (sw_wr) begin
        flag_ff[i] <= bus.reg_wdata[FL_POS];
      end
    end
  end

  // --------------------------------------------------------------------
  // Register read-back.
  // --------------------------------------------------------------------
  always_comb begin
    pri_view = 8'h00;
    pri_view[`MCUIC_PRI_GLB_EN]   = glb_en_ff;
    pri_view[`MCUIC_PRI_EXT_EN]   = en_ff[0];
    pri_view[`MCUIC_PRI_T0_EN]    = en_ff[1];
    pri_view[`MCUIC_PRI_T1_EN]    = en_ff[2];
    pri_view[`MCUIC_PRI_EXT_FLAG] = flag_ff[0];
    pri_view[`MCUIC_PRI_T0_FLAG]  = flag_ff[1];
    pri_view[`MCUIC_PRI_T1_FLAG]  = flag_ff[2];
    sec_view = 8'h00;
    sec_view[`MCUIC_SEC_ADC_EN]   = en_ff[3];
    sec_view[`MCUIC_SEC_ADC_FLAG] = flag_ff[3];
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (bus.reg_rd) begin
      rdata_ff <= (bus.reg_addr == `MCUIC_OFS_SECONDARY) ? sec_view
                                                         : pri_view;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Wake-up and pin configuration.
  // --------------------------------------------------------------------
  // Wake needs only an enabled flag, not the global enable, so a core
  // sleeping with interrupts masked can still be woken and poll.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= bus.power_down && (|pend);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pull_ff    <= 1'b0;
      pin_irq_ff <= 1'b0;
    end else begin
      pull_ff    <= pull_high_option;
      pin_irq_ff <= en_ff[0] && port_a_dir_bit5;
    end
  end

  assign bus.irq_take   = take_ff;
  assign bus.irq_vector = vector_ff;
  assign bus.wake       = wake_ff;
  assign bus.reg_rdata  = rdata_ff;
  assign pull_high_en   = pull_ff;
  assign ext_pin_is_irq = pin_irq_ff;

endmodule

`default_nettype wire

// >>> verilog/mcuic_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcuic_regs.svh"

module mcuic_core
  import mcuic_pkg::*;
#(
  parameter int PC_W  = 12,
  parameter int DEPTH = `MCUIC_STACK_DEPTH,
  parameter int DIV   = `MCUIC_PHASE_DIV
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  mcuic_if.core                bus,
  input  wire logic            sw_addr,
  input  wire logic [7:0]      sw_wdata,
  input  wire logic            sw_wr,
  input  wire logic            sw_rd,
  output var  logic [7:0]      sw_rdata,
  input  wire logic [PC_W-1:0] insn_pc,
  input  wire logic            reti_strobe,
  input  wire logic            sleep_req,
  output var  logic            pc_load,
  output var  logic [PC_W-1:0] pc_target,
  output var  logic [3:0]      stack_depth,
  output var  logic            asleep
);

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  logic [PC_W-1:0]   stack_mem [DEPTH];
  logic [3:0]        sp_ff;
  logic [3:0]        div_ff;
  logic              phase_ff;
  logic              load_ff;
  logic [PC_W-1:0]   target_ff;
  mcuic_core_state_t state_ff;

  assign bus.reg_addr  = sw_addr;
  assign bus.reg_wdata = sw_wdata;
  assign bus.reg_wr    = sw_wr;
  assign bus.reg_rd    = sw_rd;
  assign sw_rdata      = bus.reg_rdata;

  // --------------------------------------------------------------------
  // Machine phase pulse.
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_ff   <= 4'h0;
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= (div_ff == 4'(DIV - 1));
      div_ff   <= (div_ff == 4'(DIV - 1)) ? 4'h0 : div_ff + 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // Stack and program counter redirect.
  // --------------------------------------------------------------------
  // An interrupt entry takes the edge; a return in the same cycle is
  // dropped, which cannot happen while the handler is still entering.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_ff     <= 4'h0;
      load_ff   <= 1'b0;
      target_ff <= '0;
    end else begin
      load_ff <= 1'b0;
      if (bus.irq_take && (sp_ff < 4'(DEPTH))) begin
        stack_mem[sp_ff[2:0]] <= insn_pc;
        sp_ff     <= sp_ff + 4'h1;
        target_ff <= bus.irq_vector;
        load_ff   <= 1'b1;
      end else if (reti_strobe && (sp_ff != 4'h0)) begin
        sp_ff     <= sp_ff - 4'h1;
        target_ff <= stack_mem[3'(sp_ff - 4'h1)];
        load_ff   <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Power down.
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= MCUIC_RUN;
    end else begin
      unique case (state_ff)
        MCUIC_RUN:   if (sleep_req) begin
          state_ff <= MCUIC_SLEEP;
        end
        MCUIC_SLEEP: if (bus.wake) begin
          state_ff <= MCUIC_RUN;
        end
      endcase
    end
  end

  assign bus.phase_two  = phase_ff;
  assign bus.stack_full = (sp_ff >= 4'(DEPTH));
  assign bus.power_down = (state_ff == MCUIC_SLEEP);
  assign pc_load        = load_ff;
  assign pc_target      = target_ff;
  assign stack_depth    = sp_ff;
  assign asleep         = (state_ff == MCUIC_SLEEP);

endmodule

`default_nettype wire

// >>> dv/mcuic_properties.sv
`timescale 1ns/10ps
`default_nettype none

module mcuic_properties #(
  parameter int PC_W = 12
) (
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  input wire logic            phase_two,
  input wire logic            stack_full,
  input wire logic            power_down,
  input wire logic            irq_take,
  input wire logic [PC_W-1:0] irq_vector,
  input wire logic            wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Acceptance sequences
  // ----------------------------------------------------------------
  sequence s_take;
    irq_take;
  endsequence
  sequence s_glb_quiet;
    !(reg_wr && !reg_addr && reg_wdata[0]);
  endsequence

  a_take_on_phase : assert property (irq_take |-> $past(phase_two))
    else $error("Take without a phase pulse.");
  a_phase_spacing : assert property (phase_two |=> !phase_two [*3])
    else $error("Phase pulses too close.");
  a_full_blocks : assert property (irq_take |-> !$past(stack_full))
    else $error("Take while the stack was full.");
  a_no_nesting : assert property (s_take ##1 s_glb_quiet [*6] |-> !irq_take)
    else $error("Second take without global re-enable.");
  a_vector_legal : assert property (irq_take |->
    irq_vector inside {12'h004, 12'h008, 12'h00C, 12'h010})
    else $error("Vector outside the four fixed addresses.");
  a_vector_holds : assert property (!irq_take && !$past(sys_rst) |->
    $stable(irq_vector))
    else $error("Vector moved without a take.");
  a_rdata_idle : assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("Read data outside the answer cycle.");
  a_rsvd_zero : assert property ($past(reg_rd) |-> ($past(reg_addr) ?
    (reg_rdata & 8'hEE) == 8'h00 : !reg_rdata[7]))
    else $error("Unused register bit read as one.");
  a_wake_sleep : assert property (wake |-> $past(power_down))
    else $error("Wake outside power down.");
endmodule

`default_nettype wire

// >>> dv/tb_mcu_four_source_interrupt_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module tb_mcu_four_source_interrupt_ctrl
  import mcuic_pkg::*;
;
  logic clk, sys_rst, pin, pull, dir, t0_ovf, t1_ovf, adc_done;
  logic sw_addr, sw_wr, sw_rd, reti, sleep, pc_load, asleep, pull_en, pin_irq;
  logic [7:0] sw_wdata, sw_rdata;
  logic [11:0] pc_target, pc;
  logic [3:0] stack_depth;
  int compares, err_total, n;
  logic [11:0] vec [4] = '{12'h004, 12'h008, 12'h00C, 12'h010};
  logic [7:0] pri [4] = '{8'h6E, 8'h4E, 8'h0E, 8'h0E};
  logic [7:0] sec [4] = '{8'h11, 8'h11, 8'h11, 8'h01};
  logic [7:0] pen [4] = '{8'h04, 8'h08, 8'h00, 8'h02};
  logic [7:0] sen [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
  logic [3:0] evm [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  logic [7:0] cur;

  mcuic_if bus_if ();
  mcuic_dev mcuic_dev_i (.clk(clk), .sys_rst(sys_rst),
    .bus(bus_if), .port_a_line5(pin), .port_a_dir_bit5(dir),
    .pull_high_option(pull), .timer0_ovf(t0_ovf), .timer1_ovf(t1_ovf),
    .adc_done(adc_done), .pull_high_en(pull_en), .ext_pin_is_irq(pin_irq));
  mcuic_core mcuic_core_i (.clk(clk),
    .sys_rst(sys_rst), .bus(bus_if), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .insn_pc(pc),
    .reti_strobe(reti), .sleep_req(sleep), .pc_load(pc_load),
    .pc_target(pc_target), .stack_depth(stack_depth), .asleep(asleep));
  mcuic_properties mcuic_properties_i (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(bus_if.reg_addr),
    .reg_wdata(bus_if.reg_wdata), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_rdata(bus_if.reg_rdata),
    .phase_two(bus_if.phase_two), .stack_full(bus_if.stack_full),
    .power_down(bus_if.power_down), .irq_take(bus_if.irq_take),
    .irq_vector(bus_if.irq_vector), .wake(bus_if.wake));

  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic a, input logic [7:0] e);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 chk({4'h0, sw_rdata}, {4'h0, e});
  endtask
  // With m[3] set the pin goes low for one cycle, making one falling edge; m[2:0] pulse adc_done, t1_ovf, t0_ovf.
  task automatic fire(input logic [3:0] m);
    @(posedge clk);
    {pin, adc_done, t1_ovf, t0_ovf} <= {~m[3], m[2:0]};
    @(posedge clk);
    {pin, adc_done, t1_ovf, t0_ovf} <= 4'h8;
  endtask
  task automatic wait_take(input logic [11:0] v);
    #1 n = 0;
    while (bus_if.irq_take !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk({11'h000, bus_if.irq_take}, 12'h001);
    chk(bus_if.irq_vector, v);
    @(posedge clk);
    #1 chk({11'h000, pc_load}, 12'h001);
    chk(pc_target, v);
  endtask
  task automatic no_take(input int c);
    repeat (c) begin
      @(posedge clk);
      #1 chk({11'h000, bus_if.irq_take}, 12'h000);
    end
  endtask
  task automatic ret(input logic [11:0] e);
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    #1 chk({11'h000, pc_load}, 12'h001);
    chk(pc_target, e);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000 err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, pin, pull, dir} = 4'hF;
    pc = 12'h123;
    {t0_ovf, t1_ovf, adc_done, sw_addr, sw_wr, sw_rd, reti, sleep} = 8'h00;
    sw_wdata = 8'h00;
    compares = 0;
    err_total = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(1'b0, 8'h00);
    rd(1'b1, 8'h00);
    wr(1'b0, 8'h02);
    @(posedge clk);
    #1 chk({10'h000, pin_irq, pull_en}, 12'h003);
    fire(4'h8);
    rd(1'b0, 8'h12);
    wr(1'b0, 8'h13);
    wait_take(12'h004);
    chk({8'h00, stack_depth}, 12'h001);
    rd(1'b0, 8'h02);
    ret(12'h123);
    chk({8'h00, stack_depth}, 12'h000);
    wr(1'b0, 8'h04);
    fire(4'h1);
    rd(1'b0, 8'h24);
    wr(1'b0, 8'h20);
    rd(1'b0, 8'h20);
    wr(1'b0, 8'h21);
    no_take(8);
    wr(1'b0, 8'h0E);
    wr(1'b1, 8'h01);
    fire(4'hF);
    rd(1'b0, 8'h7E);
    rd(1'b1, 8'h11);
    no_take(8);
    cur = 8'h7E;
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, cur | 8'h01);
      wait_take(vec[i]);
      rd(1'b0, pri[i]);
      rd(1'b1, sec[i]);
      ret(12'h123);
      cur = pri[i];
    end
    for (int i = 0; i < 6; i++) begin
      fire(4'h1);
      pc <= 12'h200 + 12'(i);
      wr(1'b0, 8'h25);
      wait_take(12'h008);
    end
    fire(4'h1);
    wr(1'b0, 8'h25);
    no_take(12);
    rd(1'b0, 8'h25);
    ret(12'h205);
    wait_take(12'h008);
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, pen[i]);
      wr(1'b1, sen[i]);
      @(posedge clk);
      sleep <= 1'b1;
      @(posedge clk);
      sleep <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({11'h000, asleep}, 12'h001);
      fire(evm[i]);
      n = 0;
      while (asleep !== 1'b0 && n < 10) begin
        @(posedge clk);
        #1 n++;
      end
      chk({11'h000, asleep}, 12'h000);
    end
    // With the line set as an output the pin must not raise a request.
    wr(1'b0, 8'h02);
    dir <= 1'b0;
    pull <= 1'b0;
    fire(4'h8);
    rd(1'b0, 8'h02);
    chk({10'h000, pin_irq, pull_en}, 12'h000);
    summarize();
  end
endmodule

`default_nettype wire
